// >>> hw/cec_ctl_map.svh
// Purpose: register offsets, field positions and reset values
// Assumes: byte addresses on a 32-bit register bus
// Notes: definitions only
`ifndef CEC_CTL_MAP_SVH
`define CEC_CTL_MAP_SVH

`define CEC_OFS_ENABLE 8'h00
`define CEC_OFS_ADDR 8'h04
`define CEC_OFS_RESET 8'h08
`define CEC_OFS_RXEN 8'h0c
`define CEC_OFS_RXCFG1 8'h14
`define CEC_OFS_RXCFG2 8'h18
`define CEC_OFS_RXCFG3 8'h1c

`define CEC_BIT_MOD_EN 0
`define CEC_BIT_IDLE_RUN 1
`define CEC_BIT_SOFT_RST 0
`define CEC_BIT_RX_EN 0
`define CEC_BCAST_ADDR 4'hf

`define CEC_RST_ENABLE 2'h0
`define CEC_RST_ADDR 16'h0000
`define CEC_RST_RXCFG 32'h0000_0000
`define CEC_RX_SYNC_CYC 3'h3

`endif

// >>> hw/cec_ctl_pkg.sv
// Purpose: shared types of the control slice
// Assumes: map header holds the numbers
// Notes: none
`default_nettype none
package cec_ctl_pkg;

  typedef struct packed {
    logic        hit;
    logic        bcast;
    logic [3:0]  dest;
  } cec_ctl_hdr_t;

  typedef struct packed {
    logic        run;
    logic        soft_rst;
    logic        rx_en;
  } cec_ctl_ctrl_t;

  typedef enum logic [1:0] {
    CEC_RX_OFF  = 2'b00,
    CEC_RX_WAKE = 2'b01,
    CEC_RX_ON   = 2'b10,
    CEC_RX_STOP = 2'b11
  } cec_ctl_rx_st_t;

endpackage
`default_nettype wire

// >>> hw/cec_ctl_addr_match.sv
// Purpose: decides receive and acknowledge for a header destination
// Assumes: dest valid in the same cycle as the mask
// Notes: combinational
`timescale 1ns/100ps
`default_nettype none
`include "cec_ctl_map.svh"
module cec_ctl_addr_match
  import cec_ctl_pkg::*;
(
  input wire logic [15:0] mask_i,
  input wire logic [3:0] dest_i,
  output var cec_ctl_hdr_t hdr_o
);

  logic [15:0] hit_vec;

  // One compare per logical address
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_bit
      assign hit_vec[gi] = mask_i[gi] && (dest_i == 4'(gi));
    end
  endgenerate

  always_comb
  begin
    hdr_o.dest = dest_i;
    hdr_o.bcast = (dest_i == `CEC_BCAST_ADDR);
    hdr_o.hit = |hit_vec;
  end

endmodule
`default_nettype wire

// >>> hw/cec_ctl_rx_sync.sv
// Purpose: receiver start and stop with a settling delay
// Assumes: clock enable gates all state except kill_i, which clears it whatever ce_i is
// Notes: state shows the live receiver condition
`timescale 1ns/100ps
`default_nettype none
`include "cec_ctl_map.svh"
module cec_ctl_rx_sync
  import cec_ctl_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic req_i,
  input wire logic kill_i,
  output logic running_o
);

  cec_ctl_rx_st_t st_r;
  logic [2:0] cnt_r;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= CEC_RX_OFF;
      cnt_r <= 3'h0;
    end
    else if (kill_i)
    begin
      st_r <= CEC_RX_OFF;
      cnt_r <= 3'h0;
    end
    else if (ce_i)
    begin
      unique case (st_r)
        CEC_RX_OFF:
          if (req_i)
          begin
            st_r <= CEC_RX_WAKE;
            cnt_r <= `CEC_RX_SYNC_CYC;
          end
        CEC_RX_WAKE:
          if (!req_i)
            st_r <= CEC_RX_OFF;
          else if (cnt_r == 3'h1)
            st_r <= CEC_RX_ON;
          else
            cnt_r <= cnt_r - 3'h1;
        CEC_RX_ON:
          if (!req_i)
          begin
            st_r <= CEC_RX_STOP;
            cnt_r <= `CEC_RX_SYNC_CYC;
          end
        CEC_RX_STOP:
          if (req_i)
            st_r <= CEC_RX_ON;
          else if (cnt_r == 3'h1)
            st_r <= CEC_RX_OFF;
          else
            cnt_r <= cnt_r - 3'h1;
      endcase
    end
  end

  assign running_o = (st_r == CEC_RX_ON) || (st_r == CEC_RX_STOP);

endmodule
`default_nettype wire

// >>> hw/cec_ctl_top.sv
// Purpose: enable, address mask, soft reset and receive enable of a
//   single-wire control bus transceiver, over AXI4-Lite
// Assumes: one write and one read at a time; inputs synchronous
// Notes:
`timescale 1ns/100ps
`default_nettype none
`include "cec_ctl_map.svh"
module cec_ctl_top
  import cec_ctl_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic idle_mode_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hdr_valid_i,
  input wire logic [3:0] hdr_dest_i,
  output logic mod_clk_en_o,
  output logic soft_rst_o,
  output logic rx_run_o,
  output logic [31:0] rx_config_1_o,
  output logic [31:0] rx_config_2_o,
  output logic [31:0] rx_config_3_o,
  output logic hdr_accept_o,
  output logic hdr_ack_o
);

  logic module_enable_r;
  logic idle_run_enable_r;
  logic [15:0] own_address_mask_r;
  logic receive_enable_r;
  logic [31:0] rx_cfg_r [3];
  logic soft_rst_r;
  logic aw_got_r, w_got_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_go, rd_go, soft_pulse, run_en;
  logic rx_running;
  logic [31:0] rd_nxt;
  logic rd_ok_nxt, wr_ok;
  cec_ctl_hdr_t hdr;

  // idle mode stops unless idle-run set
  assign run_en = ce_i && module_enable_r &&
                  (!idle_mode_i || idle_run_enable_r);

  // Write address and data captured in either order
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end
    else if (ce_i)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_got_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      else if (wr_go)
        w_got_r <= 1'b0;
    end
  end

  assign wr_go = aw_got_r && w_got_r && !s_axi_bvalid;

  // Ready flags registered from the next handshake state
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end
    else if (ce_i)
    begin
      s_axi_awready <= !(s_axi_awvalid && s_axi_awready) && !aw_got_r &&
                       !wr_go && !(s_axi_bvalid && !s_axi_bready);
      s_axi_wready <= !(s_axi_wvalid && s_axi_wready) && !w_got_r &&
                      !wr_go && !(s_axi_bvalid && !s_axi_bready);
      s_axi_arready <= !(s_axi_arvalid && s_axi_arready) &&
                       !(s_axi_rvalid && !s_axi_rready);
    end
  end

  always_comb
  begin
    unique case (aw_addr_r)
      `CEC_OFS_ENABLE, `CEC_OFS_ADDR, `CEC_OFS_RESET, `CEC_OFS_RXEN,
      `CEC_OFS_RXCFG1, `CEC_OFS_RXCFG2, `CEC_OFS_RXCFG3:
        wr_ok = 1'b1;
      default:
        wr_ok = 1'b0;
    endcase
  end

  // reset pulse straight from the write
  assign soft_pulse = wr_go && (aw_addr_r == `CEC_OFS_RESET) &&
                      w_strb_r[0] && w_data_r[`CEC_BIT_SOFT_RST];

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end
    else if (ce_i)
    begin
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Enable register: never touched by soft reset
  // enable survives soft reset
  // both bits written in one access
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      module_enable_r <= 1'b0;
      idle_run_enable_r <= 1'b0;
    end
    else if (ce_i && wr_go && aw_addr_r == `CEC_OFS_ENABLE && w_strb_r[0])
    begin
      module_enable_r <= w_data_r[`CEC_BIT_MOD_EN];
      idle_run_enable_r <= w_data_r[`CEC_BIT_IDLE_RUN];
    end
  end

  // Other registers: written only while running; soft reset clears them whenever ce_i is high
  // settings held while disabled
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      own_address_mask_r <= `CEC_RST_ADDR;
      receive_enable_r <= 1'b0;
      for (int i = 0; i < 3; i++)
        rx_cfg_r[i] <= `CEC_RST_RXCFG;
    end
    else if (ce_i && soft_pulse)
    begin
      own_address_mask_r <= `CEC_RST_ADDR;
      receive_enable_r <= 1'b0;
      for (int i = 0; i < 3; i++)
        rx_cfg_r[i] <= `CEC_RST_RXCFG;
    end
    else if (run_en && wr_go)
    begin
      unique case (aw_addr_r)
        `CEC_OFS_ADDR:
        begin
          if (w_strb_r[0])
            own_address_mask_r[7:0] <= w_data_r[7:0];
          if (w_strb_r[1])
            own_address_mask_r[15:8] <= w_data_r[15:8];
        end
        `CEC_OFS_RXEN:
          if (w_strb_r[0])
            receive_enable_r <= w_data_r[`CEC_BIT_RX_EN];
        `CEC_OFS_RXCFG1, `CEC_OFS_RXCFG2, `CEC_OFS_RXCFG3:
          for (int b = 0; b < 4; b++)
            if (w_strb_r[b])
              rx_cfg_r[2'((aw_addr_r - `CEC_OFS_RXCFG1) >> 2)][b*8 +: 8]
                <= w_data_r[b*8 +: 8];
        default:
        begin
        end
      endcase
    end
  end

  cec_ctl_rx_sync u_rx_sync (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(run_en),
    .req_i(receive_enable_r),
    .kill_i(ce_i && soft_pulse),
    .running_o(rx_running)
  );

  cec_ctl_addr_match u_match (
    .mask_i(own_address_mask_r),
    .dest_i(hdr_dest_i),
    .hdr_o(hdr)
  );

  // Read path
  // unused bits read zero
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    rd_ok_nxt = 1'b1;
    unique case (s_axi_araddr)
      `CEC_OFS_ENABLE:
      begin
        rd_nxt[`CEC_BIT_MOD_EN] = module_enable_r;
        rd_nxt[`CEC_BIT_IDLE_RUN] = idle_run_enable_r;
      end
      `CEC_OFS_ADDR:
        rd_nxt[15:0] = own_address_mask_r;
      `CEC_OFS_RESET:
        rd_nxt = 32'h0000_0000;
      `CEC_OFS_RXEN:
        rd_nxt[`CEC_BIT_RX_EN] = rx_running;
      `CEC_OFS_RXCFG1:
        rd_nxt = rx_cfg_r[0];
      `CEC_OFS_RXCFG2:
        rd_nxt = rx_cfg_r[1];
      `CEC_OFS_RXCFG3:
        rd_nxt = rx_cfg_r[2];
      default:
        rd_ok_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end
    else if (ce_i)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_nxt;
        s_axi_rresp <= rd_ok_nxt ? 2'b00 : 2'b10;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Registered outputs toward the rest of the transceiver
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mod_clk_en_o <= 1'b0;
      soft_rst_o <= 1'b0;
      rx_run_o <= 1'b0;
      rx_config_1_o <= `CEC_RST_RXCFG;
      rx_config_2_o <= `CEC_RST_RXCFG;
      rx_config_3_o <= `CEC_RST_RXCFG;
      hdr_accept_o <= 1'b0;
      hdr_ack_o <= 1'b0;
    end
    else if (ce_i)
    begin
      mod_clk_en_o <= run_en;
      soft_rst_o <= soft_pulse;
      rx_run_o <= rx_running && !soft_pulse;
      rx_config_1_o <= rx_cfg_r[0];
      rx_config_2_o <= rx_cfg_r[1];
      rx_config_3_o <= rx_cfg_r[2];
      hdr_accept_o <= hdr_valid_i && run_en && rx_running &&
                      (hdr.bcast || hdr.hit);
      // broadcast ack only with bit 15
      hdr_ack_o <= hdr_valid_i && run_en && rx_running && hdr.hit;
    end
  end

endmodule
`default_nettype wire

// >>> bench/cec_ctl_properties.sv
// Purpose: port checks of the control slice
// Assumes: one clock, asynchronous reset
// Notes: bound to the top module
`timescale 1ns/100ps
`default_nettype none
module cec_ctl_chk
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic hdr_valid_i,
  input wire logic [3:0] hdr_dest_i,
  input wire logic mod_clk_en_o,
  input wire logic soft_rst_o,
  input wire logic rx_run_o,
  input wire logic [31:0] rx_config_1_o,
  input wire logic hdr_accept_o,
  input wire logic hdr_ack_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  a_gated_no_accept: assert property (
    hdr_accept_o |-> mod_clk_en_o)
    else $error("header taken while module stopped");
  a_bcast_taken: assert property (
    hdr_valid_i && hdr_dest_i == 4'hf && mod_clk_en_o && rx_run_o
    |=> hdr_accept_o)
    else $error("broadcast header not taken");
  a_rx_off_drop: assert property (
    hdr_valid_i && !rx_run_o |=> !hdr_accept_o)
    else $error("header taken with receiver stopped");
  a_rst_single_pulse: assert property (
    soft_rst_o |=> !soft_rst_o)
    else $error("soft reset longer than one cycle");
  a_rst_stops_rx: assert property (
    soft_rst_o |=> !rx_run_o ##1 !hdr_accept_o)
    else $error("receiver still running after soft reset");
  a_rst_no_drive: assert property (
    soft_rst_o |=> !hdr_ack_o)
    else $error("line driven after soft reset");
  a_rst_clears_cfg: assert property (
    soft_rst_o |=> (rx_config_1_o == 32'h0))
    else $error("config kept after soft reset");
  a_ack_needs_match: assert property (
    hdr_ack_o |-> hdr_accept_o && $past(hdr_valid_i))
    else $error("acknowledge without taken header");
endmodule
bind cec_ctl_top cec_ctl_chk i_chk
(
  .clk_sys_i, .sys_rst_i, .hdr_valid_i, .hdr_dest_i, .mod_clk_en_o,
  .soft_rst_o, .rx_run_o, .rx_config_1_o, .hdr_accept_o, .hdr_ack_o
);
`default_nettype wire

// >>> bench/cec_hdr_src.sv
// Purpose: far-side device sending header destinations
// Assumes: one header per call
// Notes: idle address toggles so it is never trusted
`timescale 1ns/100ps
`default_nettype none
module cec_hdr_src
(
  input wire logic clk_sys_i,
  output logic hdr_valid_o,
  output logic [3:0] hdr_dest_o
);
  initial
  begin
    hdr_valid_o = 1'b0;
    hdr_dest_o = 4'h0;
  end
  task send(input logic [3:0] dest);
    @(posedge clk_sys_i);
    hdr_valid_o <= 1'b1;
    hdr_dest_o <= dest;
    @(posedge clk_sys_i);
    hdr_valid_o <= 1'b0;
    hdr_dest_o <= ~dest;
  endtask
endmodule
`default_nettype wire

// >>> bench/test_cec_enable_address_reset_ctrl.sv
// Purpose: self-checking bench of the control slice
// Assumes: register writes answer within the watchdog span
// Notes: none
`timescale 1ns/100ps
`default_nettype none
`include "cec_ctl_map.svh"
module test_cec_enable_address_reset_ctrl;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic idle_mode_i = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, hdr_valid_i, mod_clk_en_o, soft_rst_o, rx_run_o;
  logic hdr_accept_o, hdr_ack_o;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rx_config_1_o, rx_config_2_o, rx_config_3_o;
  logic [3:0] hdr_dest_i;
  int n_errors = 0, n_tests = 0, n_pulse = 0;
  cec_ctl_top i_dut
  (
    .clk_sys_i, .sys_rst_i, .ce_i, .idle_mode_i, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .hdr_valid_i, .hdr_dest_i, .mod_clk_en_o, .soft_rst_o, .rx_run_o,
    .rx_config_1_o, .rx_config_2_o, .rx_config_3_o, .hdr_accept_o,
    .hdr_ack_o
  );
  cec_hdr_src i_src
  (
    .clk_sys_i, .hdr_valid_o(hdr_valid_i), .hdr_dest_o(hdr_dest_i)
  );
  always #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
    if (soft_rst_o === 1'b1) n_pulse++;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (s_axi_awvalid || s_axi_wvalid || s_axi_bvalid !== 1'b1)
    begin
      @(posedge clk_sys_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'h0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (s_axi_arvalid || s_axi_rvalid !== 1'b1)
    begin
      @(posedge clk_sys_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(32'(s_axi_rresp), 32'(er));
    if (er == 2'b00) chk(s_axi_rdata, exp);
  endtask
  task hdr(input logic [3:0] d, input logic ea, input logic ek);
    logic acc, ack;
    acc = 1'b0;
    ack = 1'b0;
    i_src.send(d);
    repeat (3)
    begin
      @(negedge clk_sys_i);
      acc = acc | hdr_accept_o;
      ack = ack | hdr_ack_o;
    end
    chk(32'(acc), 32'(ea));
    chk(32'(ack), 32'(ek));
  endtask
  task t_reset;
    rd(`CEC_OFS_ENABLE, 32'h0, 2'b00);
    rd(`CEC_OFS_ADDR, 32'h0, 2'b00);
    rd(8'h20, 32'h0, 2'b10);
    chk(32'(mod_clk_en_o), 32'h0);
  endtask
  task t_enable;
    wr(`CEC_OFS_ENABLE, 32'hffff_ffff);
    rd(`CEC_OFS_ENABLE, 32'h3, 2'b00);
    idle_mode_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk(32'(mod_clk_en_o), 32'h1);
    wr(`CEC_OFS_ENABLE, 32'h1);
    repeat (4) @(posedge clk_sys_i);
    chk(32'(mod_clk_en_o), 32'h0);
    idle_mode_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    chk(32'(mod_clk_en_o), 32'h1);
    ce_i <= 1'b0;
    idle_mode_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk(32'(mod_clk_en_o), 32'h1);
    ce_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk(32'(mod_clk_en_o), 32'h0);
    idle_mode_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
  endtask
  task t_mask(input logic [15:0] m);
    wr(`CEC_OFS_RXEN, 32'h0);
    repeat (8) @(posedge clk_sys_i);
    wr(`CEC_OFS_ADDR, {16'hffff, m});
    rd(`CEC_OFS_ADDR, {16'h0, m}, 2'b00);
    for (int i = 0; i < 3; i++)
      wr(`CEC_OFS_RXCFG1 + 8'(4 * i), 32'h0100_0000 + i);
    wr(`CEC_OFS_RXEN, 32'h1);
    rd(`CEC_OFS_RXEN, 32'h0, 2'b00);
    chk(32'(rx_run_o), 32'h0);
    repeat (8) @(posedge clk_sys_i);
    rd(`CEC_OFS_RXEN, 32'h1, 2'b00);
    chk(rx_config_2_o, 32'h0100_0001);
    for (int d = 0; d < 16; d++)
      hdr(4'(d), m[d] | (d == 15), m[d]);
  endtask
  task t_disable;
    wr(`CEC_OFS_ENABLE, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    chk(32'(mod_clk_en_o), 32'h0);
    hdr(4'h0, 1'b0, 1'b0);
    wr(`CEC_OFS_ADDR, 32'h0000_00ff);
    wr(`CEC_OFS_ENABLE, 32'h1);
    rd(`CEC_OFS_ADDR, 32'h1, 2'b00);
    rd(`CEC_OFS_RXEN, 32'h1, 2'b00);
  endtask
  task t_soft;
    n_pulse = 0;
    wr(`CEC_OFS_RESET, 32'h1);
    repeat (4) @(posedge clk_sys_i);
    chk(32'(n_pulse), 32'h1);
    chk(32'(rx_run_o), 32'h0);
    chk(rx_config_3_o, 32'h0);
    chk(rx_config_2_o, 32'h0);
    rd(`CEC_OFS_RESET, 32'h0, 2'b00);
    rd(`CEC_OFS_ADDR, 32'h0, 2'b00);
    rd(`CEC_OFS_ENABLE, 32'h1, 2'b00);
    hdr(4'hf, 1'b0, 1'b0);
  endtask
  task give_verdict;
    $display("errors %0d, comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #(25 * 20000);
    n_errors++;
    give_verdict;
  end
  initial
  begin
    repeat (16) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_reset;
    t_enable;
    t_mask(16'h8421);
    t_mask(16'h0001);
    t_disable;
    t_soft;
    give_verdict;
  end
endmodule
`default_nettype wire
